// >>> eid_pkg.sv
// Constants shared by the external request detector and its channels.
// Assumes an 8-bit register port with a 3-bit word address.
package eid_pkg;
	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NUM_INPUTS = 6;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [2:0] ADDR_STATUS = 3'h0;
	localparam logic [2:0] ADDR_ENABLE = 3'h1;
	localparam logic [2:0] ADDR_SENSE = 3'h2;
	localparam logic [2:0] ADDR_PRIO_A = 3'h3;
	localparam logic [2:0] ADDR_SYSCTL = 3'h4;
	// ----------------------------------------
	// Reset values and field positions
	// ----------------------------------------
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] SENSE_RESET = 8'h00;
	localparam logic [7:0] PRIO_A_RESET = 8'h00;
	localparam logic [7:0] SYSCTL_RESET = 8'h00;
	localparam int NMI_EDGE_BIT = 0;
	localparam int PRIO_BIT_IN0 = 7;
	localparam int PRIO_BIT_IN1 = 6;
	localparam int PRIO_BIT_IN23 = 5;
	localparam int PRIO_BIT_IN45 = 4;
	localparam logic [5:0] WAKE_MASK = 6'h07;
	// ----------------------------------------
	// Vector numbers
	// ----------------------------------------
	localparam logic [7:0] VEC_NMI = 8'h07;
	localparam logic [7:0] VEC_EXT_BASE = 8'h0c;
	localparam logic [7:0] VEC_NONE = 8'h00;
endpackage

// >>> eid_chan_if.sv
// Control and status bundle between the register block and one channel.
// Assumes one instance per external request input.
`timescale 1ns/1ps
interface eid_chan_if;
	logic sense;
	logic rd_status;
	logic wr_status;
	logic wr_bit;
	logic ack;
	logic flag;
	modport ctrl (
		output sense,
		output rd_status,
		output wr_status,
		output wr_bit,
		output ack,
		input flag
	);
	modport chan (
		input sense,
		input rd_status,
		input wr_status,
		input wr_bit,
		input ack,
		output flag
	);
endinterface

// >>> eid_chan.sv
// One external request channel: pin synchroniser, sense logic, pending flag.
// Assumes the pin is asynchronous and idles high; standby clears the flag and armed state like reset, but not the synchroniser.
`timescale 1ns/1ps
module eid_chan (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_standby,
	input wire logic i_pin_n,
	eid_chan_if.chan bus
);
	// ----------------------------------------
	// Pin capture
	// ----------------------------------------
	logic sync1_reg;
	logic sync2_reg;
	logic prev_reg;
	logic flag_reg;
	logic flag_next;
	logic armed_reg;
	logic armed_next;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
			prev_reg <= 1'b1;
		end else begin
			sync1_reg <= i_pin_n;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	// ----------------------------------------
	// Flag logic
	// ----------------------------------------
	wire pin_low = !sync2_reg;
	wire set_level = !bus.sense && pin_low;
	wire set_edge = bus.sense && prev_reg && pin_low;
	wire set_evt = set_level || set_edge;
	// Only a zero written after a read that saw the flag set clears it
	wire clr_sw = bus.wr_status && !bus.wr_bit && armed_reg;
	wire clr_ack = bus.ack && (bus.sense || !pin_low);

	// Set wins over any clear in the same cycle
	assign flag_next = set_evt ? 1'b1 : ((clr_sw || clr_ack) ? 1'b0 : flag_reg);
	// Any status write ends the read-then-write sequence
	assign armed_next = bus.wr_status ? 1'b0 : ((bus.rd_status && flag_reg) ? 1'b1 : armed_reg);

	always_ff @(posedge i_mclk) begin
		if (i_rst || i_standby) begin
			flag_reg <= 1'b0;
			armed_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
			armed_reg <= armed_next;
		end
	end

	assign bus.flag = flag_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_level_set;
		@(posedge i_mclk) disable iff (i_rst || i_standby)
		(!bus.sense && !sync2_reg) |=> flag_reg;
	endproperty
	a_level_set: assert property (p_level_set) else $error("level low did not set flag");

	property p_edge_set;
		@(posedge i_mclk) disable iff (i_rst || i_standby)
		(bus.sense && $fell(sync2_reg)) |=> flag_reg;
	endproperty
	a_edge_set: assert property (p_edge_set) else $error("falling edge did not set flag");

	property p_clear_needs_read;
		@(posedge i_mclk) disable iff (i_rst || i_standby)
		(flag_reg && !armed_reg && !bus.ack) |=> flag_reg;
	endproperty
	a_clear_needs_read: assert property (p_clear_needs_read) else $error("flag cleared without read");

	property p_ack_level;
		@(posedge i_mclk) disable iff (i_rst || i_standby)
		(bus.ack && !bus.sense && sync2_reg) |=> !flag_reg;
	endproperty
	a_ack_level: assert property (p_ack_level) else $error("level ack with pin high kept flag");

	property p_ack_edge;
		@(posedge i_mclk) disable iff (i_rst || i_standby)
		(bus.ack && bus.sense && !(prev_reg && !sync2_reg)) |=> !flag_reg;
	endproperty
	a_ack_edge: assert property (p_ack_edge) else $error("edge ack kept flag");

	property p_no_spurious_set;
		@(posedge i_mclk) disable iff (i_rst || i_standby)
		(!flag_reg && !set_evt) |=> !flag_reg;
	endproperty
	a_no_spurious_set: assert property (p_no_spurious_set) else $error("flag set without pin event");

	c_edge_set: cover property (@(posedge i_mclk) disable iff (i_rst) bus.sense && set_edge ##1 flag_reg);
	c_sw_clear: cover property (@(posedge i_mclk) disable iff (i_rst) clr_sw && !set_evt ##1 !flag_reg);
endmodule

// >>> eid_top.sv
// External request detector: six maskable inputs and the non-maskable input.
// Assumes a simple strobed register port and per-source exception acks.
//
// Functional notes
// - Level mode: a low pin sets that input's pending flag.
// - Edge mode: a high-to-low pin transition sets the pending flag.
// - Software clears a flag by reading it set, then writing zero.
// - Level mode: exception handling with pin high clears the flag.
// - Edge mode: exception handling always clears the flag; a new falling edge in that same cycle keeps it set.
// - Writing one to a flag does nothing; zero may only clear.
// - Status bits 7 and 6 ignore writes and read zero.
// - Status, enable and sense registers clear on reset and hardware standby.
// - Enable bits 5 to 0 enable their input when one; reset disabled.
// - Enable and sense bits 7 and 6 are plain storage without effect.
// - Sense bit zero selects low level, one selects falling edge.
// - Non-maskable request has top priority and ignores the CPU mask.
// - A system control bit picks rising or falling non-maskable edge.
// - Non-maskable exception handling uses vector seven.
// - Inputs 0 to 5 use vectors 12 to 17 in order.
// - Requests are detected whatever the pin's port direction.
// - Non-maskable and inputs 0 to 2 wake from software standby; 3 to 5 don't.
// - Six input priorities come from four bits of priority register A.
// - Priority A bits 7,6,5,4 serve inputs 0, 1, 2-3, 4-5; one is high.
`timescale 1ns/1ps
module eid_top (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_hw_standby,
	input wire logic [eid_pkg::NUM_INPUTS-1:0] i_ext_int_pin_n,
	input wire logic i_nmi_pin,
	input wire logic [eid_pkg::NUM_INPUTS-1:0] i_irq_ack,
	input wire logic i_nmi_ack,
	input wire logic [eid_pkg::ADDR_W-1:0] i_addr,
	input wire logic [eid_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [eid_pkg::DATA_W-1:0] o_rdata,
	output logic [eid_pkg::NUM_INPUTS-1:0] o_irq_req,
	output logic [eid_pkg::NUM_INPUTS-1:0] o_irq_level,
	output logic o_nmi_req,
	output logic o_int_req,
	output logic [7:0] o_vector,
	output logic o_wake
);
	localparam int N = eid_pkg::NUM_INPUTS;

	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	wire sel_status = (i_addr == eid_pkg::ADDR_STATUS);
	wire sel_enable = (i_addr == eid_pkg::ADDR_ENABLE);
	wire sel_sense = (i_addr == eid_pkg::ADDR_SENSE);
	wire sel_prio = (i_addr == eid_pkg::ADDR_PRIO_A);
	wire sel_sysctl = (i_addr == eid_pkg::ADDR_SYSCTL);
	wire wr_status = i_wr && sel_status;
	wire rd_status = i_rd && sel_status;

	logic [7:0] enable_reg;
	logic [7:0] sense_reg;
	logic [7:0] prio_a_reg;
	logic [7:0] sysctl_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [N-1:0] flag_vec;
	logic [N-1:0] req_reg;
	logic [N-1:0] level_reg;
	logic nmi_pend_reg;
	logic nmi_pend_next;
	logic [7:0] vector_reg;
	logic [7:0] vector_next;
	logic wake_reg;

	// Whole bytes are stored; bits 7:6 of enable and sense feed nothing
	always_ff @(posedge i_mclk) begin
		if (i_rst || i_hw_standby) begin
			enable_reg <= eid_pkg::ENABLE_RESET;
			sense_reg <= eid_pkg::SENSE_RESET;
			prio_a_reg <= eid_pkg::PRIO_A_RESET;
			sysctl_reg <= eid_pkg::SYSCTL_RESET;
		end else if (i_wr) begin
			if (sel_enable) begin
				enable_reg <= i_wdata;
			end
			if (sel_sense) begin
				sense_reg <= i_wdata;
			end
			if (sel_prio) begin
				prio_a_reg <= i_wdata;
			end
			if (sel_sysctl) begin
				sysctl_reg <= i_wdata;
			end
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	wire [7:0] status_view = {2'b00, flag_vec} & {2'b00, 6'h3f};
	assign rdata_next = !i_rd ? 8'h00 :
		sel_status ? status_view :
		sel_enable ? enable_reg :
		sel_sense ? sense_reg :
		sel_prio ? prio_a_reg :
		sel_sysctl ? sysctl_reg : 8'h00;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end
	assign o_rdata = rdata_reg;

	// ----------------------------------------
	// Channels
	// ----------------------------------------
	// Pins come straight from the pad, so port direction does not matter
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gen_chan
			eid_chan_if cif();
			assign cif.sense = sense_reg[g];
			assign cif.rd_status = rd_status;
			assign cif.wr_status = wr_status;
			assign cif.wr_bit = i_wdata[g];
			assign cif.ack = i_irq_ack[g];
			assign flag_vec[g] = cif.flag;
			eid_chan u_chan (
				.i_mclk(i_mclk),
				.i_rst(i_rst),
				.i_standby(i_hw_standby),
				.i_pin_n(i_ext_int_pin_n[g]),
				.bus(cif)
			);
		end
	endgenerate

	// ----------------------------------------
	// Non-maskable input
	// ----------------------------------------
	logic nmi_s1_reg;
	logic nmi_s2_reg;
	logic nmi_prev_reg;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			nmi_s1_reg <= 1'b1;
			nmi_s2_reg <= 1'b1;
			nmi_prev_reg <= 1'b1;
		end else begin
			nmi_s1_reg <= i_nmi_pin;
			nmi_s2_reg <= nmi_s1_reg;
			nmi_prev_reg <= nmi_s2_reg;
		end
	end

	wire nmi_rise_sel = sysctl_reg[eid_pkg::NMI_EDGE_BIT];
	wire nmi_rise = !nmi_prev_reg && nmi_s2_reg;
	wire nmi_fall = nmi_prev_reg && !nmi_s2_reg;
	wire nmi_evt = nmi_rise_sel ? nmi_rise : nmi_fall;
	// New edge wins over an ack in the same cycle
	assign nmi_pend_next = nmi_evt ? 1'b1 : (i_nmi_ack ? 1'b0 : nmi_pend_reg);

	// ----------------------------------------
	// Arbitration outputs
	// ----------------------------------------
	wire [N-1:0] req_next = flag_vec & enable_reg[N-1:0];
	wire [N-1:0] level_next = {prio_a_reg[eid_pkg::PRIO_BIT_IN45],
		prio_a_reg[eid_pkg::PRIO_BIT_IN45],
		prio_a_reg[eid_pkg::PRIO_BIT_IN23],
		prio_a_reg[eid_pkg::PRIO_BIT_IN23],
		prio_a_reg[eid_pkg::PRIO_BIT_IN1],
		prio_a_reg[eid_pkg::PRIO_BIT_IN0]};
	wire [N-1:0] req_hi = req_next & level_next;
	wire [N-1:0] req_pick = (req_hi != '0) ? req_hi : req_next;

	// Lowest index wins inside a level, matching the default order
	function automatic logic [7:0] pick_vector(input logic [N-1:0] req);
		logic [7:0] v;
		v = eid_pkg::VEC_NONE;
		for (int k = N - 1; k >= 0; k--) begin
			if (req[k]) begin
				v = eid_pkg::VEC_EXT_BASE + 8'(k);
			end
		end
		return v;
	endfunction

	// NMI is chosen first and never looks at the enable or CPU mask
	assign vector_next = nmi_pend_reg ? eid_pkg::VEC_NMI : pick_vector(req_pick);

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			req_reg <= '0;
			level_reg <= '0;
			nmi_pend_reg <= 1'b0;
			vector_reg <= eid_pkg::VEC_NONE;
			wake_reg <= 1'b0;
		end else begin
			req_reg <= req_next;
			level_reg <= level_next;
			nmi_pend_reg <= nmi_pend_next;
			vector_reg <= vector_next;
			wake_reg <= nmi_evt || nmi_pend_reg || ((flag_vec & eid_pkg::WAKE_MASK) != '0);
		end
	end

	assign o_irq_req = req_reg;
	assign o_irq_level = level_reg;
	assign o_nmi_req = nmi_pend_reg;
	assign o_int_req = nmi_pend_reg || (req_reg != '0);
	assign o_vector = vector_reg;
	assign o_wake = wake_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_resv_zero;
		@(posedge i_mclk) disable iff (i_rst)
		rd_status |=> (o_rdata[7:6] == 2'b00);
	endproperty
	a_resv_zero: assert property (p_resv_zero) else $error("status bits 7:6 not zero");

	property p_standby_clear;
		@(posedge i_mclk) disable iff (i_rst)
		i_hw_standby |=> (enable_reg == 8'h00 && sense_reg == 8'h00 && flag_vec == '0);
	endproperty
	a_standby_clear: assert property (p_standby_clear) else $error("standby did not clear");

	property p_req_gate;
		@(posedge i_mclk) disable iff (i_rst || i_hw_standby)
		##1 (o_irq_req == ($past(flag_vec) & $past(enable_reg[N-1:0])));
	endproperty
	a_req_gate: assert property (p_req_gate) else $error("request not flag and enable");

	property p_nmi_vector;
		@(posedge i_mclk) disable iff (i_rst)
		nmi_pend_reg |=> (o_vector == eid_pkg::VEC_NMI);
	endproperty
	a_nmi_vector: assert property (p_nmi_vector) else $error("nmi vector not seven");

	property p_nmi_masked_ignored;
		@(posedge i_mclk) disable iff (i_rst)
		(nmi_evt && enable_reg == 8'h00) |=> o_nmi_req ##1 (o_vector == eid_pkg::VEC_NMI);
	endproperty
	a_nmi_masked_ignored: assert property (p_nmi_masked_ignored) else $error("nmi not taken");

	property p_nmi_edge;
		@(posedge i_mclk) disable iff (i_rst)
		(!nmi_pend_reg && !(nmi_rise_sel ? nmi_rise : nmi_fall)) |=> !nmi_pend_reg;
	endproperty
	a_nmi_edge: assert property (p_nmi_edge) else $error("nmi set on wrong edge");

	property p_vec_in0;
		@(posedge i_mclk) disable iff (i_rst)
		(!nmi_pend_reg && req_next == 6'h01) |=> (o_vector == 8'h0c);
	endproperty
	a_vec_in0: assert property (p_vec_in0) else $error("input 0 vector not 12");

	property p_prio_high;
		@(posedge i_mclk) disable iff (i_rst)
		(!nmi_pend_reg && req_next == 6'h21 && level_next == 6'h30) |=> (o_vector == 8'h11);
	endproperty
	a_prio_high: assert property (p_prio_high) else $error("high level input 5 lost");

	property p_no_wake_hi;
		@(posedge i_mclk) disable iff (i_rst)
		(!nmi_evt && !nmi_pend_reg && (flag_vec & eid_pkg::WAKE_MASK) == '0) |=> !o_wake;
	endproperty
	a_no_wake_hi: assert property (p_no_wake_hi) else $error("inputs 3 to 5 woke device");

	// ----------------------------------------
	// Register and output checks
	// ----------------------------------------
	// No disable here: what reset leaves behind is the point
	property p_reset_clear;
		@(posedge i_mclk)
		i_rst |=> (enable_reg == 8'h00 && sense_reg == 8'h00 && flag_vec == '0 &&
			o_rdata == 8'h00 && o_irq_req == '0 && !o_nmi_req && !o_wake);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset left state behind");

	property p_enable_store;
		@(posedge i_mclk) disable iff (i_rst || i_hw_standby)
		(i_wr && sel_enable) |=> (enable_reg == $past(i_wdata));
	endproperty
	a_enable_store: assert property (p_enable_store) else $error("enable byte not stored");

	property p_sense_store;
		@(posedge i_mclk) disable iff (i_rst || i_hw_standby)
		(i_wr && sel_sense) |=> (sense_reg == $past(i_wdata));
	endproperty
	a_sense_store: assert property (p_sense_store) else $error("sense byte not stored");

	property p_prio_store;
		@(posedge i_mclk) disable iff (i_rst || i_hw_standby)
		(i_wr && sel_prio) |=> (prio_a_reg == $past(i_wdata));
	endproperty
	a_prio_store: assert property (p_prio_store) else $error("priority byte not stored");

	property p_sysctl_store;
		@(posedge i_mclk) disable iff (i_rst || i_hw_standby)
		(i_wr && sel_sysctl) |=> (sysctl_reg == $past(i_wdata));
	endproperty
	a_sysctl_store: assert property (p_sysctl_store) else $error("system byte not stored");

	property p_level_low_pair;
		@(posedge i_mclk) disable iff (i_rst)
		##1 (o_irq_level[1:0] == {$past(prio_a_reg[6]), $past(prio_a_reg[7])});
	endproperty
	a_level_low_pair: assert property (p_level_low_pair) else $error("input 0 or 1 level wrong");

	property p_level_shared;
		@(posedge i_mclk) disable iff (i_rst)
		##1 (o_irq_level[5:2] == {{2{$past(prio_a_reg[4])}}, {2{$past(prio_a_reg[5])}}});
	endproperty
	a_level_shared: assert property (p_level_shared) else $error("shared level wrong");

	property p_req_disabled;
		@(posedge i_mclk) disable iff (i_rst)
		(enable_reg[N-1:0] == '0) |=> (o_irq_req == '0);
	endproperty
	a_req_disabled: assert property (p_req_disabled) else $error("disabled input requested");

	property p_vec_none;
		@(posedge i_mclk) disable iff (i_rst)
		(!nmi_pend_reg && req_next == '0) |=> (o_vector == eid_pkg::VEC_NONE);
	endproperty
	a_vec_none: assert property (p_vec_none) else $error("vector without request");

	property p_nmi_ack;
		@(posedge i_mclk) disable iff (i_rst)
		(i_nmi_ack && !nmi_evt) |=> !o_nmi_req;
	endproperty
	a_nmi_ack: assert property (p_nmi_ack) else $error("nmi ack did not clear");

	property p_wake_low;
		@(posedge i_mclk) disable iff (i_rst)
		(flag_vec[2:0] != 3'h0) |=> o_wake;
	endproperty
	a_wake_low: assert property (p_wake_low) else $error("inputs 0 to 2 did not wake");

	c_nmi: cover property (@(posedge i_mclk) disable iff (i_rst) nmi_evt ##1 o_nmi_req);
	c_req: cover property (@(posedge i_mclk) disable iff (i_rst) req_next != '0 ##1 o_int_req);
	c_wake: cover property (@(posedge i_mclk) disable iff (i_rst) flag_vec[0] ##1 o_wake);
endmodule

// >>> eid_pin_drv.sv
// Model of the external devices that drive the request pins.
// Assumes the bench commands wanted levels; the pins idle high.
`timescale 1ns/1ps
module eid_pin_drv (
	input wire logic i_mclk,
	input wire logic i_slow,
	input wire logic [5:0] i_want_n,
	input wire logic i_want_nmi,
	output logic [5:0] o_pin_n,
	output logic o_nmi_pin
);
	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	logic [6:0] dly_reg [3];
	initial begin
		for (int k = 0; k < 3; k++) begin
			dly_reg[k] = 7'h7f;
		end
	end
	// Slow devices answer three edges late; pulse widths are kept
	always @(posedge i_mclk) begin
		dly_reg[0] <= {i_want_nmi, i_want_n};
		dly_reg[1] <= dly_reg[0];
		dly_reg[2] <= dly_reg[1];
	end
	// Plain driven levels, whatever the port direction; pins serve no other use
	assign {o_nmi_pin, o_pin_n} = i_slow ? dly_reg[2] : dly_reg[0];
endmodule

// >>> tb_top.sv
// Self-checking bench for the external request detector.
// Assumes the pin model in eid_pin_drv and the register port of eid_top.
`timescale 1ns/1ps
module tb_top;
	// ----------------------------------------
	// Signals and model state
	// ----------------------------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic stby = 1'b0;
	logic slow = 1'b0;
	logic [5:0] want_n = 6'h3f;
	logic want_nmi = 1'b1;
	logic [5:0] pin_n;
	logic nmi_pin;
	logic [5:0] ack = 6'h00;
	logic nmi_ack = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [7:0] rdata;
	logic [5:0] irq_req;
	logic [5:0] irq_lvl;
	logic nmi_req;
	logic int_req;
	logic [7:0] vec;
	logic wake;
	int fails = 0;
	int cmp_count = 0;
	int m_flag[6] = '{0, 0, 0, 0, 0, 0};
	int m_en = 0;
	int m_prio = 0;
	int m_nmi = 0;
	logic [31:0] lfsr_reg = 32'ha433;
	always #4 clk = ~clk;
	eid_pin_drv i_pins (.i_mclk(clk), .i_slow(slow), .i_want_n(want_n), .i_want_nmi(want_nmi),
		.o_pin_n(pin_n), .o_nmi_pin(nmi_pin));
	eid_top i_dut (.i_mclk(clk), .i_rst(rst), .i_hw_standby(stby), .i_ext_int_pin_n(pin_n),
		.i_nmi_pin(nmi_pin), .i_irq_ack(ack), .i_nmi_ack(nmi_ack), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .o_irq_req(irq_req),
		.o_irq_level(irq_lvl), .o_nmi_req(nmi_req), .o_int_req(int_req), .o_vector(vec),
		.o_wake(wake));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic int lvl_of(input int i);
		return (i < 2) ? m_prio[7 - i] : m_prio[6 - i / 2];
	endfunction
	function automatic logic [7:0] exp_vec();
		if (m_nmi != 0) return 8'h07;
		for (int p = 1; p >= 0; p--) begin
			for (int i = 0; i < 6; i++) begin
				if (m_flag[i] != 0 && m_en[i] && lvl_of(i) == p) return 8'(12 + i);
			end
		end
		return 8'h00;
	endfunction
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
	task automatic pulse(input logic [5:0] m, input logic n);
		ack <= m;
		nmi_ack <= n;
		@(posedge clk);
		ack <= 6'h00;
		nmi_ack <= 1'b0;
		@(posedge clk);
	endtask
	task automatic settle();
		repeat (10) @(posedge clk);
	endtask
	task automatic check_all(input string name);
		logic [7:0] st;
		logic [5:0] f;
		logic [5:0] r;
		logic [5:0] l;
		for (int i = 0; i < 6; i++) begin
			f[i] = m_flag[i] != 0;
			r[i] = f[i] & m_en[i];
			l[i] = lvl_of(i);
		end
		rd(eid_pkg::ADDR_STATUS, st);
		chk(st, {2'b00, f}, "status");
		chk({2'b00, irq_req}, {2'b00, r}, "request");
		chk({2'b00, irq_lvl}, {2'b00, l}, "level");
		chk(vec, exp_vec(), "vector");
		chk({6'h00, nmi_req, int_req}, {6'h00, m_nmi[0], m_nmi[0] | (r != 0)}, "nmi");
		chk({7'h00, wake}, {7'h00, m_nmi[0] | (f[2:0] != 0)}, "wake");
		$display("test %s done", name);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		conclude();
	end
	initial begin
		logic [7:0] d;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int a = 0; a < 8; a++) begin
			rd(3'(a), d);
			chk(d, 8'h00, "reset value");
			if (a > 4) begin
				wr(3'(a), 8'hff);
				rd(3'(a), d);
				chk(d, 8'h00, "unmapped");
			end
		end
		wr(eid_pkg::ADDR_ENABLE, 8'hc0);
		wr(eid_pkg::ADDR_SENSE, 8'hc0);
		wr(eid_pkg::ADDR_STATUS, 8'hff);
		rd(eid_pkg::ADDR_ENABLE, d);
		chk(d, 8'hc0, "enable top");
		rd(eid_pkg::ADDR_SENSE, d);
		chk(d, 8'hc0, "sense top");
		check_all("storage bits");
		// Level mode, random enables and priorities per input
		for (int i = 0; i < 6; i++) begin
			lfsr_reg = lfsr_next(lfsr_reg);
			slow <= i[0];
			m_en = lfsr_reg[7:0];
			m_prio = lfsr_reg[15:8];
			wr(eid_pkg::ADDR_ENABLE, 8'(m_en));
			wr(eid_pkg::ADDR_PRIO_A, 8'(m_prio));
			rd(eid_pkg::ADDR_PRIO_A, d);
			chk(d, 8'(m_prio), "prio readback");
			want_n[i] <= 1'b0;
			settle();
			m_flag[i] = 1;
			check_all("level set");
			want_n[i] <= 1'b1;
			settle();
			wr(eid_pkg::ADDR_STATUS, 8'hff);
			wr(eid_pkg::ADDR_STATUS, 8'h00);
			check_all("clear without read");
			wr(eid_pkg::ADDR_STATUS, ~(8'h01 << i));
			m_flag[i] = 0;
			check_all("clear after read");
		end
		// Acknowledge in level mode only clears with the pin high
		want_n[1] <= 1'b0;
		settle();
		m_flag[1] = 1;
		pulse(6'h02, 1'b0);
		check_all("level ack pin low");
		want_n[1] <= 1'b1;
		settle();
		pulse(6'h02, 1'b0);
		m_flag[1] = 0;
		check_all("level ack pin high");
		// Edge mode per input
		wr(eid_pkg::ADDR_SENSE, 8'h3f);
		for (int i = 0; i < 6; i++) begin
			want_n[i] <= 1'b0;
			repeat (4) @(posedge clk);
			want_n[i] <= 1'b1;
			settle();
			m_flag[i] = 1;
			check_all("edge set");
			wr(eid_pkg::ADDR_STATUS, 8'hff);
			check_all("write ones");
			pulse(6'(1 << i), 1'b0);
			m_flag[i] = 0;
			check_all("edge ack");
		end
		// Non-maskable request beats a pending input; its pin idles high
		m_en = 8'h3f;
		wr(eid_pkg::ADDR_ENABLE, 8'h3f);
		wr(eid_pkg::ADDR_SYSCTL, 8'h01);
		want_n[3] <= 1'b0;
		repeat (4) @(posedge clk);
		want_n[3] <= 1'b1;
		want_nmi <= 1'b0;
		settle();
		m_flag[3] = 1;
		check_all("nmi fall ignored");
		want_nmi <= 1'b1;
		settle();
		m_nmi = 1;
		check_all("nmi rising");
		pulse(6'h00, 1'b1);
		m_nmi = 0;
		wr(eid_pkg::ADDR_SYSCTL, 8'h00);
		want_nmi <= 1'b0;
		settle();
		m_nmi = 1;
		check_all("nmi falling");
		pulse(6'h00, 1'b1);
		m_nmi = 0;
		want_nmi <= 1'b1;
		settle();
		check_all("nmi ack");
		// Hardware standby clears the registers and input flags, but not the non-maskable pending bit
		stby <= 1'b1;
		@(posedge clk);
		stby <= 1'b0;
		settle();
		m_en = 0;
		m_prio = 0;
		m_flag[3] = 0;
		rd(eid_pkg::ADDR_ENABLE, d);
		chk(d, 8'h00, "standby enable");
		rd(eid_pkg::ADDR_SENSE, d);
		chk(d, 8'h00, "standby sense");
		check_all("standby");
		conclude();
	end
endmodule
